/* verilog/adc_dma_params.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ADC_DMA_PARAMS_SVH
`define ADC_DMA_PARAMS_SVH

`define OFS_TIMING  8'h00
`define OFS_CHMODE  8'h04
`define OFS_AUX     8'h08
`define OFS_PTR_LO  8'h0C
`define OFS_PTR_MID 8'h10
`define OFS_PTR_PG  8'h14
`define OFS_RESULT  8'h18
`define OFS_STATUS  8'h1C

`define RST_TIMING  8'h20
`define RST_CHMODE  8'h00

`define F_MD        7:6
`define F_CK        5:4
`define F_AQ        3:2
`define B_T2C       1
`define B_EXC       0
`define B_DONE      7
`define B_DMA       6
`define B_CCONV     5
`define B_SCONV     4
`define F_CS        3:0

`define CONV_LAST   4'hE
`define STOP_ID     4'hF
`define SLOT_STEP   24'h000002

`endif

/* verilog/adc_dma_pkg.sv */
// state types shared by the sequencer and the conversion timer
package adc_dma_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SYNC = 2'b01,
    PH_ACQ  = 2'b10,
    PH_CONV = 2'b11
  } phase_type;
  typedef enum logic [2:0] {
    MS_IDLE    = 3'b000,
    MS_CHK     = 3'b001,
    MS_WR_HI   = 3'b010,
    MS_WR_LO   = 3'b011,
    MS_RD      = 3'b100,
    MS_RD_WAIT = 3'b101,
    MS_RD_TAKE = 3'b110
  } mem_state_type;
endpackage : adc_dma_pkg

/* verilog/conv_if.sv */
// signals between the sequencer and the conversion timer
`timescale 1ns/1ps
interface conv_if;
  logic       start;
  logic       again;
  logic [1:0] ck_sel;
  logic [1:0] aq_sel;
  logic       busy;
  logic       track;
  logic       done;
  modport ctrl  (output start, again, ck_sel, aq_sel,
                 input busy, track, done);
  modport timer (input start, again, ck_sel, aq_sel,
                 output busy, track, done);
endinterface : conv_if

/* verilog/conv_timer.sv */
// converter clock divider and conversion phase counter
`timescale 1ns/1ps
`include "adc_dma_params.svh"
module conv_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sequencer side
  conv_if.timer    cv
);
  adc_dma_pkg::phase_type ph_q;
  logic [2:0]             div_q;
  logic [2:0]             ratio_m1;
  logic [3:0]             cnt_q;
  logic                   tick;
  logic                   track_q;
  logic                   done_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  always_comb begin
    unique case (cv.ck_sel)
      2'h0: ratio_m1 = 3'h0;
      2'h1: ratio_m1 = 3'h1;
      2'h2: ratio_m1 = 3'h3;
      2'h3: ratio_m1 = 3'h7;
    endcase
  end
  assign tick = (div_q >= ratio_m1);

  // held at zero while idle so the sync clock is always a full one
  always_ff @(posedge clk) begin
    if (rst || tick || ph_q == adc_dma_pkg::PH_IDLE) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q    <= adc_dma_pkg::PH_IDLE;
      cnt_q   <= 4'h0;
      track_q <= 1'h0;
      done_q  <= 1'h0;
    end else begin
      done_q <= 1'h0;
      unique case (ph_q)
        adc_dma_pkg::PH_IDLE: if (cv.start) begin
          ph_q <= adc_dma_pkg::PH_SYNC;
        end
        adc_dma_pkg::PH_SYNC: if (tick) begin
          ph_q    <= adc_dma_pkg::PH_ACQ;
          cnt_q   <= {2'h0, cv.aq_sel};
          track_q <= 1'h1;
        end
        adc_dma_pkg::PH_ACQ: if (tick) begin
          if (cnt_q == 4'h0) begin
            ph_q    <= adc_dma_pkg::PH_CONV;
            cnt_q   <= `CONV_LAST;
            track_q <= 1'h0;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        adc_dma_pkg::PH_CONV: if (tick) begin
          if (cnt_q == 4'h0) begin
            done_q <= 1'h1;
            ph_q   <= cv.again ? adc_dma_pkg::PH_SYNC
                               : adc_dma_pkg::PH_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
      endcase
    end
  end

  assign cv.busy  = (ph_q != adc_dma_pkg::PH_IDLE);
  assign cv.track = track_q;
  assign cv.done  = done_q;

  a_conv_length: assert property (
    (ph_q == adc_dma_pkg::PH_IDLE && cv.start && cv.ck_sel == 2'h0
     && cv.aq_sel == 2'h0) |-> ##18 cv.done)
    else $error("conversion did not take seventeen clocks");
  a_track_single: assert property (
    ($rose(cv.track) && cv.aq_sel == 2'h0 && cv.ck_sel == 2'h0)
    |=> !cv.track)
    else $error("track held longer than one converter clock");
  a_div_by_four: assert property (
    (cv.ck_sel == 2'h2 && tick && ph_q == adc_dma_pkg::PH_ACQ)
    |=> (!tick && cv.ck_sel == 2'h2)[*3] ##1 tick)
    else $error("converter clock is not master clock over four");
  a_back_to_back: assert property (
    (cv.done && $past(cv.again)) |-> ph_q == adc_dma_pkg::PH_SYNC)
    else $error("continuous conversion did not restart at once");
endmodule : conv_timer

/* verilog/adc_sequencer_dma.sv */
// converter sequencer with apb registers and capture engine
`timescale 1ns/1ps
`include "adc_dma_params.svh"

module adc_sequencer_dma #(
  parameter int AW = 24
) (
  // clock and reset
  input  wire logic          CLK_SYS,
  input  wire logic          RST,
  // apb slave
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output      logic [31:0]   PRDATA,
  output      logic          PREADY,
  output      logic          PSLVERR,
  // triggers and interrupt entry
  input  wire logic          TIMER2_OVF,
  input  wire logic          CONVST_N,
  input  wire logic          ISR_ACK,
  output      logic          DONE_FLAG,
  // converter core
  input  wire logic [11:0]   ADC_RESULT,
  output      logic [3:0]    ADC_CHANNEL,
  output      logic          ADC_TRACK,
  output      logic          REF_ON,
  // core side of external memory
  input  wire logic [AW-1:0] CORE_ADDR,
  input  wire logic [7:0]    CORE_WDATA,
  input  wire logic          CORE_WE,
  input  wire logic          CORE_RE,
  output      logic [7:0]    CORE_RDATA,
  // external memory
  output      logic [AW-1:0] MEM_ADDR,
  output      logic [7:0]    MEM_WDATA,
  output      logic          MEM_WE,
  output      logic          MEM_RE,
  input  wire logic [7:0]    MEM_RDATA,
  output      logic          MEM_OWN
);
  localparam logic [7:0] CH_RST = `RST_CHMODE;

  conv_if cv ();
  conv_timer u_timer (
    .clk (CLK_SYS),
    .rst (RST),
    .cv  (cv.timer)
  );

  logic [7:0]    tim_q;
  logic          dma_q;
  logic          cconv_q;
  logic          sconv_q;
  logic [3:0]    cs_q;
  logic          flag_q;
  logic [1:0]    aux_q;
  logic [AW-1:0] ptr_q;
  logic          ref_q;
  logic          pready_q;
  logic          pslverr_q;
  logic [31:0]   prdata_q;
  logic [31:0]   rd_word;
  logic          rd_hit;
  logic          acc;
  logic          wr;
  logic          t2_half_q;
  logic          convst_prev_q;
  logic          start_q;
  logic          run_q;
  logic          free_q;
  logic          stop_q;
  logic          again_q;
  logic [1:0]    dcyc_q;
  logic [3:0]    conv_ch_q;
  logic [3:0]    next_id_q;
  logic [15:0]   res_q;
  logic          have_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] mem_addr_q;
  logic [7:0]    mem_wdata_q;
  logic          mem_we_q;
  logic          mem_re_q;
  logic [7:0]    core_rdata_q;
  adc_dma_pkg::mem_state_type ms_q;

  logic powered;
  logic sw_trig;
  logic hw_trig;
  logic go_ok;
  logic dma_first;
  logic dma_next;
  logic plain;
  logic chain;
  logic kick;
  logic fin;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  // one wait state: the answer comes from flops in the access phase
  assign acc = PSEL & PENABLE & pready_q;
  assign wr  = acc & PWRITE;

  always_comb begin
    rd_hit  = 1'h1;
    rd_word = 32'h0;
    unique case (PADDR)
      `OFS_TIMING:  rd_word = {24'h0, tim_q};
      `OFS_CHMODE:  rd_word = {24'h0, flag_q, dma_q, cconv_q,
                               sconv_q, cs_q};
      `OFS_AUX:     rd_word = {30'h0, aux_q};
      `OFS_PTR_LO:  rd_word = {24'h0, ptr_q[7:0]};
      `OFS_PTR_MID: rd_word = {24'h0, ptr_q[15:8]};
      `OFS_PTR_PG:  rd_word = {{(48-AW){1'b0}}, ptr_q[AW-1:16]};
      `OFS_RESULT:  rd_word = {16'h0, res_q};
      `OFS_STATUS:  rd_word = {29'h0, ref_q, run_q, cv.busy};
      default:      rd_hit  = 1'h0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q <= PSEL & PENABLE & ~pready_q;
      if (PSEL && PENABLE && !pready_q) begin
        pslverr_q <= ~rd_hit;
        prdata_q  <= PWRITE ? 32'h0 : rd_word;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tim_q <= `RST_TIMING;
    end else if (wr && PADDR == `OFS_TIMING) begin
      tim_q <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dma_q   <= CH_RST[`B_DMA];
      cconv_q <= CH_RST[`B_CCONV];
      cs_q    <= CH_RST[`F_CS];
    end else if (wr && PADDR == `OFS_CHMODE) begin
      dma_q   <= PWDATA[`B_DMA];
      cconv_q <= PWDATA[`B_CCONV];
      cs_q    <= PWDATA[`F_CS];
    end else if (fin) begin
      cconv_q <= 1'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sconv_q <= CH_RST[`B_SCONV];
    end else if (wr && PADDR == `OFS_CHMODE) begin
      sconv_q <= PWDATA[`B_SCONV];
    end else if (fin || (cv.done && !run_q)) begin
      sconv_q <= 1'h0;
    end
  end

  // a completion in the same cycle as an acknowledge is kept
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flag_q <= CH_RST[`B_DONE];
    end else if (fin || (cv.done && !run_q)) begin
      flag_q <= 1'h1;
    end else if (ISR_ACK) begin
      flag_q <= 1'h0;
    end else if (wr && PADDR == `OFS_CHMODE) begin
      flag_q <= PWDATA[`B_DONE];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aux_q <= 2'h0;
    end else if (wr && PADDR == `OFS_AUX) begin
      aux_q <= PWDATA[1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ptr_q <= '0;
    end else if (wr && PADDR == `OFS_PTR_LO) begin
      ptr_q[7:0] <= PWDATA[7:0];
    end else if (wr && PADDR == `OFS_PTR_MID) begin
      ptr_q[15:8] <= PWDATA[7:0];
    end else if (wr && PADDR == `OFS_PTR_PG) begin
      ptr_q[AW-1:16] <= PWDATA[AW-17:0];
    end
  end

  // ----------------------------------------------------------------
  // reference and triggers
  // ----------------------------------------------------------------
  assign powered = (tim_q[`F_MD] != 2'h0);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ref_q <= 1'h0;
    end else begin
      ref_q <= powered | (|aux_q);
    end
  end

  // timer trigger fires on every second overflow
  always_ff @(posedge CLK_SYS) begin
    if (RST || !tim_q[`B_T2C]) begin
      t2_half_q <= 1'h0;
    end else if (TIMER2_OVF) begin
      t2_half_q <= ~t2_half_q;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      convst_prev_q <= 1'h1;
    end else begin
      convst_prev_q <= CONVST_N;
    end
  end

  assign hw_trig = (tim_q[`B_T2C] & TIMER2_OVF & t2_half_q)
                 | (tim_q[`B_EXC] & convst_prev_q & ~CONVST_N);
  assign sw_trig = sconv_q | cconv_q;

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  // triggers arriving while a conversion runs are ignored
  assign go_ok     = powered & ~cv.busy & ~start_q & ~cv.done;
  assign dma_first = dma_q & ~run_q & go_ok & (sw_trig | hw_trig);
  assign dma_next  = run_q & go_ok & ~stop_q & ~free_q & hw_trig;
  assign plain     = ~dma_q & go_ok & (sw_trig | hw_trig);
  assign chain     = run_q & cv.done & again_q;
  assign kick      = dma_first | dma_next | chain;
  assign fin       = run_q & cv.done & stop_q;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      start_q <= 1'h0;
    end else begin
      start_q <= dma_first | dma_next | plain;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      again_q <= 1'h0;
    end else if (run_q) begin
      again_q <= free_q & ~stop_q;
    end else begin
      again_q <= ~dma_q & cconv_q & powered;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      run_q  <= 1'h0;
      free_q <= 1'h0;
    end else if (dma_first) begin
      run_q  <= 1'h1;
      free_q <= sw_trig;
    end else if (fin) begin
      run_q  <= 1'h0;
      free_q <= 1'h0;
    end
  end

  // the first conversion only primes the pipe; its result is dropped
  always_ff @(posedge CLK_SYS) begin
    if (RST || dma_first) begin
      dcyc_q <= 2'h0;
    end else if (run_q && cv.done && dcyc_q != 2'h3) begin
      dcyc_q <= dcyc_q + 2'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      conv_ch_q <= 4'h0;
    end else if (dma_first || plain) begin
      conv_ch_q <= cs_q;
    end else if (dma_next || chain) begin
      conv_ch_q <= next_id_q;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      res_q <= 16'h0;
    end else if (cv.done) begin
      res_q <= {conv_ch_q, ADC_RESULT};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || fin || dma_first) begin
      have_q <= 1'h0;
    end else if (run_q && cv.done) begin
      have_q <= (dcyc_q != 2'h0);
    end else if (ms_q == adc_dma_pkg::MS_WR_LO) begin
      have_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // memory engine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ms_q <= adc_dma_pkg::MS_IDLE;
    end else begin
      unique case (ms_q)
        adc_dma_pkg::MS_IDLE:
          if (kick) ms_q <= adc_dma_pkg::MS_CHK;
        adc_dma_pkg::MS_CHK:
          ms_q <= have_q ? adc_dma_pkg::MS_WR_HI
                         : adc_dma_pkg::MS_RD;
        adc_dma_pkg::MS_WR_HI:   ms_q <= adc_dma_pkg::MS_WR_LO;
        adc_dma_pkg::MS_WR_LO:   ms_q <= adc_dma_pkg::MS_RD;
        adc_dma_pkg::MS_RD:      ms_q <= adc_dma_pkg::MS_RD_WAIT;
        adc_dma_pkg::MS_RD_WAIT: ms_q <= adc_dma_pkg::MS_RD_TAKE;
        adc_dma_pkg::MS_RD_TAKE: ms_q <= adc_dma_pkg::MS_IDLE;
        default:                 ms_q <= adc_dma_pkg::MS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
    end else if (dma_first) begin
      rd_ptr_q <= ptr_q;
      wr_ptr_q <= ptr_q;
    end else begin
      if (ms_q == adc_dma_pkg::MS_RD_TAKE) begin
        rd_ptr_q <= rd_ptr_q + AW'(`SLOT_STEP);
      end
      if (ms_q == adc_dma_pkg::MS_WR_LO) begin
        wr_ptr_q <= wr_ptr_q + AW'(`SLOT_STEP);
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || dma_first) begin
      next_id_q <= 4'h0;
      stop_q    <= 1'h0;
    end else if (ms_q == adc_dma_pkg::MS_RD_TAKE) begin
      next_id_q <= MEM_RDATA[7:4];
      stop_q    <= (MEM_RDATA[7:4] == `STOP_ID);
    end
  end

  // pins follow the engine state one cycle later
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mem_addr_q   <= '0;
      mem_wdata_q  <= 8'h0;
      mem_we_q     <= 1'h0;
      mem_re_q     <= 1'h0;
      core_rdata_q <= 8'h0;
    end else if (run_q) begin
      mem_we_q     <= (ms_q == adc_dma_pkg::MS_WR_HI)
                    | (ms_q == adc_dma_pkg::MS_WR_LO);
      mem_re_q     <= (ms_q == adc_dma_pkg::MS_RD);
      mem_addr_q   <= (ms_q == adc_dma_pkg::MS_WR_HI) ? wr_ptr_q
                    : (ms_q == adc_dma_pkg::MS_WR_LO)
                      ? wr_ptr_q + AW'(1) : rd_ptr_q;
      mem_wdata_q  <= (ms_q == adc_dma_pkg::MS_WR_HI)
                      ? res_q[15:8] : res_q[7:0];
      core_rdata_q <= 8'h0;
    end else begin
      mem_we_q     <= CORE_WE;
      mem_re_q     <= CORE_RE;
      mem_addr_q   <= CORE_ADDR;
      mem_wdata_q  <= CORE_WDATA;
      core_rdata_q <= MEM_RDATA;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cv.start  = start_q;
  assign cv.again  = again_q;
  assign cv.ck_sel = tim_q[`F_CK];
  assign cv.aq_sel = tim_q[`F_AQ];

  assign PRDATA      = prdata_q;
  assign PREADY      = pready_q;
  assign PSLVERR     = pslverr_q;
  assign DONE_FLAG   = flag_q;
  assign ADC_CHANNEL = conv_ch_q;
  assign ADC_TRACK   = cv.track;
  assign REF_ON      = ref_q;
  assign CORE_RDATA  = core_rdata_q;
  assign MEM_ADDR    = mem_addr_q;
  assign MEM_WDATA   = mem_wdata_q;
  assign MEM_WE      = mem_we_q;
  assign MEM_RE      = mem_re_q;
  assign MEM_OWN     = run_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wr_first;
    MEM_OWN && MEM_WE && !$past(MEM_WE);
  endsequence
  sequence s_wr_second;
    MEM_WE && MEM_ADDR == $past(MEM_ADDR) + AW'(1) ##1 !MEM_WE;
  endsequence

  a_write_pair: assert property (s_wr_first |=> s_wr_second)
    else $error("result bytes not written to consecutive locations");
  a_first_result: assert property (
    (MEM_OWN && MEM_WE) |-> dcyc_q >= 2'h2)
    else $error("result written before the third cycle");
  a_flag_on_end: assert property (fin |=> DONE_FLAG)
    else $error("done flag not set at block end");
  a_release_stop: assert property (
    fin |=> !MEM_OWN && !cv.again)
    else $error("memory not released after stop");
  a_stop_no_chain: assert property (
    $rose(stop_q) |=> !cv.again ##1 !cv.again)
    else $error("conversions chained past stop field");
  // only the engine's own write states may raise the strobe while owned
  a_core_gated: assert property (
    (MEM_OWN && CORE_WE) |=> (!MEM_WE
     || $past(ms_q) == adc_dma_pkg::MS_WR_HI
     || $past(ms_q) == adc_dma_pkg::MS_WR_LO))
    else $error("core write reached memory during capture");
  a_ref_auto_on: assert property (powered |=> REF_ON)
    else $error("reference not on with converter enabled");
  a_flag_set_wins: assert property (
    (cv.done && !run_q && ISR_ACK) |=> DONE_FLAG)
    else $error("completion lost to interrupt acknowledge");
endmodule : adc_sequencer_dma

/* verif/sram_model.sv */
// external static ram behind the capture engine
`timescale 1ns/1ps
module sram_model (
  // clock
  input  wire logic        clk,
  // memory pins
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        we,
  input  wire logic        re,
  output      logic [7:0]  rdata
);
  logic [7:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
    rdata = 8'h00;
  end
  // byte writes land where the pointer says
  always @(posedge clk) begin
    if (we) begin
      mem[addr[7:0]] <= wdata;
    end
  end
  // data is valid only the cycle after a read; otherwise it keeps toggling
  always @(posedge clk) begin
    if (re) begin
      rdata <= mem[addr[7:0]];
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : sram_model

/* verif/tb_top.sv */
// self-checking bench for the converter sequencer and capture engine
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, t2 = 1'b0, cst_n = 1'b1;
  logic isr_ack = 1'b0, done_flag, trk_o, ref_on, mem_we, mem_re, own;
  logic core_we = 1'b0, rerr;
  logic [7:0] paddr = 8'h00, core_wd = 8'h00, mem_wd, mem_rd, core_rd;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [23:0] core_a = 24'h0, mem_a;
  logic [3:0] chan;
  int err_total = 0, checks_done = 0;
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  adc_sequencer_dma u_dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TIMER2_OVF(t2),
    .CONVST_N(cst_n), .ISR_ACK(isr_ack), .DONE_FLAG(done_flag),
    .ADC_RESULT(12'hA5C), .ADC_CHANNEL(chan), .ADC_TRACK(trk_o),
    .REF_ON(ref_on), .CORE_ADDR(core_a), .CORE_WDATA(core_wd),
    .CORE_WE(core_we), .CORE_RE(1'b0), .CORE_RDATA(core_rd),
    .MEM_ADDR(mem_a), .MEM_WDATA(mem_wd), .MEM_WE(mem_we), .MEM_RE(mem_re),
    .MEM_RDATA(mem_rd), .MEM_OWN(own));
  sram_model u_mem (.clk(clk_sys), .addr(mem_a), .wdata(mem_wd),
    .we(mem_we), .re(mem_re), .rdata(mem_rd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // waits for track to rise, then counts the cycles it stays high
  task automatic trk(output int hi);
    int n;
    n = 0;
    while (trk_o !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    hi = 0;
    while (trk_o === 1'b1 && hi < 400) begin
      @(posedge clk_sys);
      hi++;
    end
  endtask : trk
  task automatic wait_done();
    int n;
    n = 0;
    while (done_flag !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (done_flag !== 1'b1) err_total++;
  endtask : wait_done
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk(rdat, 32'h20);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat, 32'h00);
    chk(ref_on, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    chk(rerr, 1'b1);
    chk(rdat, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_acq();
    logic [7:0] cfg [3] = '{8'h60, 8'h4C, 8'h5C};
    int exp [3] = '{4, 4, 8};
    int hi;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h00, {24'h0, cfg[i]});
      // settling wait shortened to the reference enable latency
      repeat (2) @(posedge clk_sys);
      chk(ref_on, 1'b1);
      apb(1'b1, 8'h04, 32'h13);
      trk(hi);
      chk(hi, exp[i]);
      chk(chan, 4'h3);
      // second pass holds the acknowledge so completion meets it
      isr_ack <= (i == 1);
      wait_done();
      isr_ack <= 1'b0;
      apb(1'b0, 8'h18, 32'h0);
      chk(rdat, 32'h3A5C);
      @(posedge clk_sys);
      isr_ack <= 1'b1;
      @(posedge clk_sys);
      isr_ack <= 1'b0;
      @(posedge clk_sys);
      chk(done_flag, 1'b0);
    end
    $display("test acquisition done");
  endtask : t_acq
  task automatic t_cont();
    int hi;
    int lo;
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b1, 8'h04, 32'h20);
    trk(hi);
    lo = 0;
    while (trk_o !== 1'b1 && lo < 100) begin
      @(posedge clk_sys);
      lo++;
    end
    chk(hi + lo, 17);
    apb(1'b1, 8'h04, 32'h00);
    repeat (40) @(posedge clk_sys);
    $display("test continuous done");
  endtask : t_cont
  task automatic t_trig();
    int hi;
    logic seen;
    apb(1'b1, 8'h00, 32'h41);
    cst_n <= 1'b0;
    trk(hi);
    chk(hi, 1);
    cst_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
    apb(1'b1, 8'h00, 32'h42);
    @(posedge clk_sys);
    t2 <= 1'b1;
    @(posedge clk_sys);
    t2 <= 1'b0;
    seen = 1'b0;
    repeat (40) begin
      @(posedge clk_sys);
      seen = seen | (trk_o === 1'b1);
    end
    chk(seen, 1'b0);
    t2 <= 1'b1;
    @(posedge clk_sys);
    t2 <= 1'b0;
    trk(hi);
    chk(hi, 1);
    repeat (40) @(posedge clk_sys);
    $display("test triggers done");
  endtask : t_trig
  task automatic t_dma();
    logic hit;
    logic [7:0] exp [8] = '{8'h2A, 8'h5C, 8'h5A, 8'h5C,
                            8'h50, 8'h00, 8'hF0, 8'h00};
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h0C, 32'h10);
    apb(1'b1, 8'h10, 32'h00);
    apb(1'b1, 8'h14, 32'h00);
    u_mem.mem[8'h10] = 8'h20;
    u_mem.mem[8'h12] = 8'h50;
    u_mem.mem[8'h14] = 8'h50;
    u_mem.mem[8'h16] = 8'hF0;
    apb(1'b1, 8'h04, 32'h40);
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b1, 8'h04, 32'h60);
    hit = 1'b0;
    for (int n = 0; n < 3000 && done_flag !== 1'b1; n++) begin
      @(posedge clk_sys);
      core_we <= (own === 1'b1) && !hit;
      core_a <= 24'h000030;
      core_wd <= 8'h77;
      if (own === 1'b1 && hit) chk(core_rd, 8'h00);
      hit = hit | (own === 1'b1);
    end
    core_we <= 1'b0;
    chk(hit, 1'b1);
    chk(done_flag, 1'b1);
    repeat (4) @(posedge clk_sys);
    chk(own, 1'b0);
    for (int i = 0; i < 8; i++) begin
      chk(u_mem.mem[8'h10 + i], exp[i]);
    end
    chk(u_mem.mem[8'h30], 8'h00);
    $display("test capture done");
  endtask : t_dma
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_acq();
    t_cont();
    t_trig();
    t_dma();
    end_sim();
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : tb_top
